// file: hdl/kldc_pkg.sv
// constants and types for the keypad led dimming controller
package kldc_pkg;
  // clock rate and documented times
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned FRAME_TIME_NS = 50000; // 50 us frame
  localparam int unsigned SOFT_START_TIME_MS = 20; // boost soft-start
  localparam int unsigned FRAME_CYC = FRAME_TIME_NS * CLK_MHZ / 1000;
  localparam int unsigned SOFT_START_CYC = SOFT_START_TIME_MS * CLK_MHZ * 1000;

  // register offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_KEYPAD = 8'h01;
  localparam logic [7:0] ADDR_EXT_SEL = 8'h06;
  localparam logic [7:0] ADDR_STATUS = 8'h10;

  // control register field positions
  localparam int unsigned CTRL_MODE_BIT = 0;
  localparam int unsigned CTRL_KEYP_EN_BIT = 1;
  localparam int unsigned CTRL_DIM_SEL_BIT = 2;
  localparam int unsigned CTRL_ON1_BIT = 3;
  localparam int unsigned CTRL_BOOST_BIT = 6;
  localparam logic [7:0] CTRL_RESET = 8'h01; // switch mode by default
  localparam logic [6:0] CTRL_MASK = 7'h7F;

  // keypad register field positions
  localparam int unsigned KP_OVL_BIT = 0;
  localparam int unsigned KP_BRIGHT_LSB = 1;
  localparam int unsigned KP_BAL_LSB = 4;
  localparam logic [7:0] KEYPAD_RESET = 8'h00;
  localparam logic [7:0] KEYPAD_MASK = 8'h7F;

  // external gate select field
  localparam int unsigned EXT_SEL_LSB = 0;
  localparam logic [7:0] EXT_SEL_RESET = 8'h00;
  localparam logic [7:0] EXT_SEL_MASK = 8'h07;

  // balance shares are expressed in twelfths of the lit part of the frame
  localparam logic [3:0] SHARE_DEN = 4'hC;

  typedef enum logic [1:0] {
    KLDC_SS_IDLE = 2'b01,
    KLDC_SS_RAMP = 2'b10
  } kldc_ss_state_t;
endpackage

// file: hdl/kldc_pwm_if.sv
// settings and waveforms passed between the register top and the frame engine
`timescale 1ns/1ps
interface kldc_pwm_if;
  logic clear;
  logic [2:0] bright;
  logic [2:0] balance;
  logic overlap;
  logic [2:0] wave;
  logic frame_start;

  modport engine (
    input clear,
    input bright,
    input balance,
    input overlap,
    output wave,
    output frame_start
  );
  modport ctrl (
    output clear,
    output bright,
    output balance,
    output overlap,
    input wave,
    input frame_start
  );
endinterface

// file: hdl/kldc_pwm_engine.sv
// 50 us frame engine producing the three dimmed slot waveforms
`timescale 1ns/1ps
module kldc_pwm_engine #(
  parameter int unsigned FRAME_CYCLES = kldc_pkg::FRAME_CYC
) (
  input wire logic clk_sys,
  input wire logic resetn,
  kldc_pwm_if.engine pif
);
  import kldc_pkg::*;

  // share of each output in twelfths, packed {one, two, three}
  function automatic logic [11:0] kldc_shares(input logic [2:0] bal);
    case (bal)
      3'h0: kldc_shares = {4'hC, 4'h0, 4'h0};
      3'h1: kldc_shares = {4'h0, 4'hC, 4'h0};
      3'h2: kldc_shares = {4'h0, 4'h0, 4'hC};
      3'h3: kldc_shares = {4'h6, 4'h6, 4'h0};
      3'h4: kldc_shares = {4'h0, 4'h6, 4'h6};
      3'h5: kldc_shares = {4'h6, 4'h0, 4'h6};
      3'h6: kldc_shares = {4'h4, 4'h4, 4'h4};
      default: kldc_shares = {4'h6, 4'h3, 4'h3};
    endcase
  endfunction

  // slot length for one share of the lit time
  function automatic logic [31:0] kldc_slot(input logic [31:0] lit, input logic [3:0] sh);
    kldc_slot = (lit * 32'(sh)) / 32'(SHARE_DEN);
  endfunction

  logic [31:0] cnt_reg, cnt_next;
  logic [2:0] bright_reg, bright_next;
  logic [2:0] bal_reg, bal_next;
  logic ovl_reg, ovl_next;
  logic [2:0] wave_reg, wave_next;
  logic fs_reg, fs_next;
  logic [31:0] lit;
  logic [31:0] end1, end2, end3;
  logic [11:0] sh;

  // lit time from the logarithmic brightness code
  always_comb begin
    if (bright_reg == 3'h0) begin
      lit = 32'h0;
    end else begin
      lit = 32'(FRAME_CYCLES) >> (3'h7 - bright_reg);
    end
    sh = kldc_shares(bal_reg);
    end1 = kldc_slot(lit, sh[11:8]);
    end2 = end1 + kldc_slot(lit, sh[7:4]);
    end3 = end2 + kldc_slot(lit, sh[3:0]);
  end

  // frame counter, settings latch and waveform
  always_comb begin
    cnt_next = cnt_reg + 32'h1;
    bright_next = bright_reg;
    bal_next = bal_reg;
    ovl_next = ovl_reg;
    fs_next = 1'b0;
    if (cnt_reg >= 32'(FRAME_CYCLES - 1)) begin
      cnt_next = 32'h0;
      bright_next = pif.bright;
      bal_next = pif.balance;
      ovl_next = pif.overlap;
      fs_next = 1'b1;
    end
    if (ovl_reg) begin
      wave_next = {3{cnt_reg < lit}};
    end else begin
      wave_next[0] = cnt_reg < end1;
      wave_next[1] = (cnt_reg >= end1) && (cnt_reg < end2);
      wave_next[2] = (cnt_reg >= end2) && (cnt_reg < end3);
    end
    if (pif.clear) begin
      cnt_next = 32'h0;
      bright_next = 3'h0;
      bal_next = 3'h0;
      ovl_next = 1'b0;
      wave_next = 3'h0;
      fs_next = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cnt_reg <= 32'h0;
      bright_reg <= 3'h0;
      bal_reg <= 3'h0;
      ovl_reg <= 1'b0;
      wave_reg <= 3'h0;
      fs_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      bright_reg <= bright_next;
      bal_reg <= bal_next;
      ovl_reg <= ovl_next;
      wave_reg <= wave_next;
      fs_reg <= fs_next;
    end
  end

  assign pif.wave = wave_reg;
  assign pif.frame_start = fs_reg;
endmodule

// file: hdl/kldc_top.sv
// keypad led dimming controller: registers, soft-start blanking and output gating
// Operation
// - mode bit high selects switch, low current sink
// - register dimming needs keypad enable and dimming select
// - each output lit only with its on bit
// - balance 6:4, brightness 3:1, overlap bit 0
// - overlap bit picks slot or simultaneous timing
// - brightness code doubles lit fraction from 1/64
// - balance ignored in overlapping timing
// - codes 000/001/010 give one output everything
// - overlapping timing switches outputs together by duty
// - fixed 50 us frame, slots one two three
// - dimmed slots shrink, frame tail stays dark
// - boost enable low puts converter in standby
// - 20 ms soft-start after enable blanks all outputs
// - without dimming select outputs follow on bits, gated by keypad enable
// - external pulse gates selected outputs active high
// - external or power reset holds register defaults
`timescale 1ns/1ps
module kldc_top #(
  parameter int unsigned FRAME_CYCLES = kldc_pkg::FRAME_CYC,
  parameter int unsigned SOFT_START_CYCLES = kldc_pkg::SOFT_START_CYC
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic external_reset_n,
  input wire logic ext_pwm_in,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic led_sink_one,
  output logic led_sink_two,
  output logic led_sink_three,
  output logic output_mode_select,
  output logic boost_run,
  output logic boost_soft_start
);
  import kldc_pkg::*;

  kldc_pwm_if pif ();

  logic ext_rst_s1_reg, ext_rst_s2_reg, ext_rst_s1_next, ext_rst_s2_next;
  logic ext_pwm_s1_reg, ext_pwm_s2_reg, ext_pwm_s1_next, ext_pwm_s2_next;
  logic clear;
  logic [7:0] ctrl_reg, ctrl_next;
  logic [7:0] keypad_reg, keypad_next;
  logic [7:0] ext_sel_reg, ext_sel_next;
  logic [7:0] rdata_reg, rdata_next;
  kldc_ss_state_t ss_reg, ss_next;
  logic [31:0] ss_cnt_reg, ss_cnt_next;
  logic boost_prev_reg, boost_prev_next;
  logic [2:0] led_reg, led_next;
  logic mode_reg, mode_next;
  logic keyp_en, dim_sel, boost_en;
  logic [2:0] on_bits, ext_sel;
  logic wr_ctrl, wr_keypad, wr_ext_sel;
  logic pend_reg, pend_next;
  logic kp_wr_d_reg, kp_wr_d_next;

  // two-flop synchronisers for the reset and pulse pins
  always_comb begin
    ext_rst_s1_next = external_reset_n;
    ext_rst_s2_next = ext_rst_s1_reg;
    ext_pwm_s1_next = ext_pwm_in;
    ext_pwm_s2_next = ext_pwm_s1_reg;
  end

  // reset pin stages start at its idle high level, so no clear follows resetn
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ext_rst_s1_reg <= 1'b1;
      ext_rst_s2_reg <= 1'b1;
      ext_pwm_s1_reg <= 1'b0;
      ext_pwm_s2_reg <= 1'b0;
    end else begin
      ext_rst_s1_reg <= ext_rst_s1_next;
      ext_rst_s2_reg <= ext_rst_s2_next;
      ext_pwm_s1_reg <= ext_pwm_s1_next;
      ext_pwm_s2_reg <= ext_pwm_s2_next;
    end
  end

  assign clear = ~ext_rst_s2_reg;

  // write strobe aimed at one register offset
  function automatic logic kldc_hit(input logic wr, input logic [7:0] a, input logic [7:0] ofs);
    kldc_hit = wr && (a == ofs);
  endfunction

  // field decode of the control and select registers
  assign keyp_en = ctrl_reg[CTRL_KEYP_EN_BIT];
  assign dim_sel = ctrl_reg[CTRL_DIM_SEL_BIT];
  assign boost_en = ctrl_reg[CTRL_BOOST_BIT];
  assign on_bits = ctrl_reg[CTRL_ON1_BIT +: 3];
  assign ext_sel = ext_sel_reg[EXT_SEL_LSB +: 3];
  assign wr_ctrl = kldc_hit(reg_wr, reg_addr, ADDR_CTRL);
  assign wr_keypad = kldc_hit(reg_wr, reg_addr, ADDR_KEYPAD);
  assign wr_ext_sel = kldc_hit(reg_wr, reg_addr, ADDR_EXT_SEL);

  // control register: mode, enables, on bits and boost enable
  always_comb begin
    ctrl_next = ctrl_reg;
    if (wr_ctrl) begin
      ctrl_next = reg_wdata & {1'b0, CTRL_MASK};
    end
    if (clear) begin
      ctrl_next = CTRL_RESET;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ctrl_reg <= CTRL_RESET;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  // dimming settings register: balance, brightness and overlap
  always_comb begin
    keypad_next = keypad_reg;
    if (wr_keypad) begin
      keypad_next = reg_wdata & KEYPAD_MASK;
    end
    if (clear) begin
      keypad_next = KEYPAD_RESET;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      keypad_reg <= KEYPAD_RESET;
    end else begin
      keypad_reg <= keypad_next;
    end
  end

  // external gate select register
  always_comb begin
    ext_sel_next = ext_sel_reg;
    if (wr_ext_sel) begin
      ext_sel_next = reg_wdata & EXT_SEL_MASK;
    end
    if (clear) begin
      ext_sel_next = EXT_SEL_RESET;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ext_sel_reg <= EXT_SEL_RESET;
    end else begin
      ext_sel_reg <= ext_sel_next;
    end
  end

  // read data of the addressed register, status built from live state
  always_comb begin
    case (reg_addr)
      ADDR_CTRL: rdata_next = ctrl_reg;
      ADDR_KEYPAD: rdata_next = keypad_reg;
      ADDR_EXT_SEL: rdata_next = ext_sel_reg;
      ADDR_STATUS: rdata_next = {3'h0, led_reg, pend_reg, ss_reg == KLDC_SS_RAMP};
      default: rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // settings handed to the frame engine, latched there at frame end
  assign pif.clear = clear;
  assign pif.bright = keypad_reg[KP_BRIGHT_LSB +: 3];
  assign pif.balance = keypad_reg[KP_BAL_LSB +: 3];
  assign pif.overlap = keypad_reg[KP_OVL_BIT];

  kldc_pwm_engine #(
    .FRAME_CYCLES(FRAME_CYCLES)
  ) u_engine (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .pif(pif)
  );

  // settings pending flag: set by a dimming write, cleared once a frame starts with it
  always_comb begin
    kp_wr_d_next = wr_keypad;
    pend_next = pend_reg;
    if (pif.frame_start && !kp_wr_d_reg) begin
      pend_next = 1'b0;
    end
    if (wr_keypad) begin
      pend_next = 1'b1; // a write wins over a frame start in the same cycle
    end
    if (clear) begin
      pend_next = 1'b0;
      kp_wr_d_next = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pend_reg <= 1'b0;
      kp_wr_d_reg <= 1'b0;
    end else begin
      pend_reg <= pend_next;
      kp_wr_d_reg <= kp_wr_d_next;
    end
  end

  // boost soft-start sequencer, started by a rising boost enable
  always_comb begin
    ss_next = ss_reg;
    ss_cnt_next = ss_cnt_reg;
    boost_prev_next = boost_en;
    case (ss_reg)
      KLDC_SS_IDLE: begin
        if (boost_en && !boost_prev_reg) begin
          ss_next = KLDC_SS_RAMP;
          ss_cnt_next = 32'(SOFT_START_CYCLES - 1);
        end
      end
      KLDC_SS_RAMP: begin
        if (!boost_en) begin
          ss_next = KLDC_SS_IDLE;
          ss_cnt_next = 32'h0;
        end else if (ss_cnt_reg == 32'h0) begin
          ss_next = KLDC_SS_IDLE;
        end else begin
          ss_cnt_next = ss_cnt_reg - 32'h1;
        end
      end
      default: begin
        ss_next = KLDC_SS_IDLE;
        ss_cnt_next = 32'h0;
      end
    endcase
    if (clear) begin
      ss_next = KLDC_SS_IDLE;
      ss_cnt_next = 32'h0;
      boost_prev_next = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ss_reg <= KLDC_SS_IDLE;
      ss_cnt_reg <= 32'h0;
      boost_prev_reg <= 1'b0;
    end else begin
      ss_reg <= ss_next;
      ss_cnt_reg <= ss_cnt_next;
      boost_prev_reg <= boost_prev_next;
    end
  end

  // per-output gating: keypad enable, on bit, dimming source, external pulse, blanking
  always_comb begin
    logic [2:0] src;
    src = 3'h0;
    for (int i = 0; i < 3; i++) begin
      if (dim_sel) begin
        src[i] = pif.wave[i];
        if (ext_sel[i]) begin
          src[i] = pif.wave[i] & ext_pwm_s2_reg;
        end
      end else begin
        src[i] = 1'b1;
        if (ext_sel[i]) begin
          src[i] = ext_pwm_s2_reg;
        end
      end
    end
    led_next = src & on_bits & {3{keyp_en}};
    if (ss_next == KLDC_SS_RAMP) begin
      led_next = 3'h0; // dark from the edge that starts the ramp
    end
    mode_next = ctrl_reg[CTRL_MODE_BIT];
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      led_reg <= 3'h0;
      mode_reg <= CTRL_RESET[CTRL_MODE_BIT];
    end else begin
      led_reg <= led_next;
      mode_reg <= mode_next;
    end
  end

  assign led_sink_one = led_reg[0];
  assign led_sink_two = led_reg[1];
  assign led_sink_three = led_reg[2];
  assign output_mode_select = mode_reg;
  assign boost_run = boost_en;
  assign boost_soft_start = ss_reg == KLDC_SS_RAMP;
  assign reg_rdata = rdata_reg;
endmodule

// file: bench/kldc_leds_model.sv
// keypad led strings that total the cycles each one conducts
`timescale 1ns/1ps
module kldc_leds_model (
  input wire logic clk_sys,
  input wire logic clr,
  input wire logic [2:0] sink_on,
  output logic [2:0][31:0] lit
);
  // a string lights only while its sink conducts
  always_ff @(posedge clk_sys) begin
    for (int k = 0; k < 3; k++) begin
      lit[k] <= clr ? 32'h0 : lit[k] + 32'(sink_on[k]);
    end
  end
endmodule

// file: bench/kldc_sva.sv
// port assertions for the keypad led dimming controller
`timescale 1ns/1ps
module kldc_sva #(
  parameter int unsigned FRAME_CYCLES = 192,
  parameter int unsigned SOFT_START_CYCLES = 50
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic led_sink_one,
  input wire logic led_sink_two,
  input wire logic led_sink_three,
  input wire logic output_mode_select,
  input wire logic boost_run,
  input wire logic boost_soft_start
);
  import kldc_pkg::*;
  logic [2:0] leds;
  logic [7:0] ctrl_sh, ctrl_nx, kp_sh, kp_nx, ext_sh, ext_nx;
  logic [31:0] age, age_nx, ss_cnt, ss_nx;
  logic wr_ctrl;
  assign leds = {led_sink_three, led_sink_two, led_sink_one};
  assign wr_ctrl = reg_wr && reg_addr == ADDR_CTRL;
  // shadow settings, cycles since a write, soft-start length
  always_comb begin
    ctrl_nx = wr_ctrl ? reg_wdata : ctrl_sh;
    kp_nx = (reg_wr && reg_addr == ADDR_KEYPAD) ? reg_wdata : kp_sh;
    ext_nx = (reg_wr && reg_addr == ADDR_EXT_SEL) ? reg_wdata : ext_sh;
    age_nx = reg_wr ? 32'h0 : age + 32'h1;
    ss_nx = boost_soft_start ? ss_cnt + 32'h1 : 32'h0;
  end
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ctrl_sh <= CTRL_RESET;
      kp_sh <= KEYPAD_RESET;
      ext_sh <= EXT_SEL_RESET;
      age <= 32'h0;
      ss_cnt <= 32'h0;
    end else begin
      ctrl_sh <= ctrl_nx;
      kp_sh <= kp_nx;
      ext_sh <= ext_nx;
      age <= age_nx;
      ss_cnt <= ss_nx;
    end
  end
  default clocking dcb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);
  property p_reset_out;
    $rose(resetn) |-> leds == 3'b000 && output_mode_select;
  endproperty
  a_reset_out: assert property (p_reset_out) else $error("outputs wrong after reset");
  property p_mode;
    wr_ctrl ##1 !wr_ctrl |-> ##1 output_mode_select == $past(reg_wdata[CTRL_MODE_BIT], 2);
  endproperty
  a_mode: assert property (p_mode) else $error("mode output wrong");
  property p_boost;
    wr_ctrl ##1 !wr_ctrl |-> ##1 boost_run == $past(reg_wdata[CTRL_BOOST_BIT], 2);
  endproperty
  a_boost: assert property (p_boost) else $error("boost enable wrong");
  property p_blank;
    boost_soft_start |-> leds == 3'b000;
  endproperty
  a_blank: assert property (p_blank) else $error("led lit in soft-start");
  property p_ss_len;
    $fell(boost_soft_start) && boost_run |-> ss_cnt == SOFT_START_CYCLES;
  endproperty
  a_ss_len: assert property (p_ss_len) else $error("soft-start length wrong");
  property p_on_bits;
    (leds & ~$past(ctrl_sh[5:3] & {3{ctrl_sh[1]}})) == 3'b000;
  endproperty
  a_on_bits: assert property (p_on_bits) else $error("led lit while off");
  property p_no_ovl;
    !kp_sh[0] && ctrl_sh[2] && age > FRAME_CYCLES + 4 |-> $onehot0(leds);
  endproperty
  a_no_ovl: assert property (p_no_ovl) else $error("slots overlap");
  property p_ovl;
    kp_sh[0] && ctrl_sh[5:1] == 5'h1F && ext_sh[2:0] == 3'h0 && age > FRAME_CYCLES + 4
      |-> leds == 3'b000 || leds == 3'b111;
  endproperty
  a_ovl: assert property (p_ovl) else $error("outputs not together");
endmodule

// file: bench/keypad_led_dimming_controller_tb_top.sv
// self-checking bench for the keypad led dimming controller
`timescale 1ns/1ps
module keypad_led_dimming_controller_tb_top;
  import kldc_pkg::*;
  localparam int unsigned FRM = 192;
  localparam int unsigned SSC = 50;
  localparam int unsigned SHR [8][3] = '{'{12, 0, 0}, '{0, 12, 0}, '{0, 0, 12}, '{6, 6, 0},
    '{0, 6, 6}, '{6, 0, 6}, '{4, 4, 4}, '{6, 3, 3}};
  logic clk_sys, resetn, external_reset_n, ext_pwm_in, reg_wr, clr;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic led_sink_one, led_sink_two, led_sink_three, output_mode_select, boost_run;
  logic boost_soft_start;
  logic [5:0] st;
  logic [2:0][31:0] lit;
  int fails, total_checks;
  int unsigned lt;
  assign st = {boost_run, boost_soft_start, output_mode_select, led_sink_three, led_sink_two,
    led_sink_one};
  kldc_top #(.FRAME_CYCLES(FRM), .SOFT_START_CYCLES(SSC)) u_kldc_top (.clk_sys(clk_sys),
    .resetn(resetn), .external_reset_n(external_reset_n), .ext_pwm_in(ext_pwm_in),
    .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .led_sink_one(led_sink_one), .led_sink_two(led_sink_two), .led_sink_three(led_sink_three),
    .output_mode_select(output_mode_select), .boost_run(boost_run),
    .boost_soft_start(boost_soft_start));
  kldc_leds_model u_kldc_leds_model (.clk_sys(clk_sys), .clr(clr),
    .sink_on({led_sink_three, led_sink_two, led_sink_one}), .lit(lit));
  // comparison, register access and lit-time measurement
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    repeat (2) @(posedge clk_sys);
    #1;
    chk(32'(reg_rdata), 32'(exp));
  endtask
  task automatic wait_chk(input int unsigned n, input logic [5:0] exp);
    repeat (n) @(posedge clk_sys);
    #1;
    chk(32'(st), 32'(exp));
  endtask
  task automatic meas(input int unsigned e1, input int unsigned e2, input int unsigned e3);
    repeat (2 * FRM + 4) @(posedge clk_sys);
    clr <= 1'b1;
    @(posedge clk_sys);
    clr <= 1'b0;
    repeat (4 * FRM) @(posedge clk_sys);
    #1;
    chk(lit[0], 32'(4 * e1));
    chk(lit[1], 32'(4 * e2));
    chk(lit[2], 32'(4 * e3));
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // clock
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  // hang guard
  initial begin
    repeat (60000) @(posedge clk_sys);
    fails++;
    $display("timeout at %0t", $time);
    end_of_test();
  end
  // test sequence
  initial begin
    resetn = 1'b0;
    external_reset_n = 1'b1;
    ext_pwm_in = 1'b1;
    reg_wr = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    clr = 1'b0;
    fails = 0;
    total_checks = 0;
    repeat (10) @(posedge clk_sys);
    resetn <= 1'b1;
    rd(ADDR_CTRL, CTRL_RESET);
    rd(ADDR_KEYPAD, KEYPAD_RESET);
    rd(ADDR_EXT_SEL, EXT_SEL_RESET);
    rd(8'h20, 8'h00);
    wr(ADDR_KEYPAD, 8'hFF);
    rd(ADDR_KEYPAD, 8'h7F);
    $display("registers done");
    wr(ADDR_CTRL, 8'h0B);
    wait_chk(3, 6'h09);
    wr(ADDR_CTRL, 8'h3A);
    wait_chk(3, 6'h07);
    $display("static done");
    wr(ADDR_CTRL, 8'h7A);
    wait_chk(3, 6'h30);
    wait_chk(SSC + 2, 6'h27);
    wr(ADDR_CTRL, 8'h3A);
    wr(ADDR_CTRL, 8'h7A);
    wr(ADDR_CTRL, 8'h3A);
    wait_chk(3, 6'h07);
    $display("boost done");
    wr(ADDR_CTRL, 8'h3E);
    for (int i = 0; i < 8; i++) begin
      wr(ADDR_KEYPAD, {1'b0, 3'b010, 3'(i), 1'b1});
      lt = (i == 0) ? 0 : FRM >> (7 - i);
      meas(lt, lt, lt);
    end
    $display("overlap done");
    for (int i = 0; i < 8; i++) begin
      wr(ADDR_KEYPAD, {1'b0, 3'(i), 3'b111, 1'b0});
      meas(FRM * SHR[i][0] / 12, FRM * SHR[i][1] / 12, FRM * SHR[i][2] / 12);
    end
    wr(ADDR_KEYPAD, 8'h6C);
    meas(FRM / 2 * 4 / 12, FRM / 2 * 4 / 12, FRM / 2 * 4 / 12);
    // align to a frame start, then change settings mid-frame
    wr(ADDR_KEYPAD, 8'h0D);
    repeat (2 * FRM) @(posedge clk_sys);
    lt = 0;
    for (int n = 0; n < 2 * FRM && lt != 2; n++) begin
      @(posedge clk_sys);
      #1;
      lt = led_sink_one ? ((lt == 1) ? 2 : lt) : 1;
    end
    chk(lt, 2);
    wr(ADDR_KEYPAD, 8'h01);
    rd(ADDR_STATUS, 8'h1E);
    wait_chk(20, 6'h07);
    wait_chk(2 * FRM, 6'h00);
    rd(ADDR_STATUS, 8'h00);
    $display("slots done");
    wr(ADDR_KEYPAD, 8'h0F);
    wr(ADDR_EXT_SEL, 8'h01);
    ext_pwm_in <= 1'b0;
    meas(0, FRM, FRM);
    ext_pwm_in <= 1'b1;
    meas(FRM, FRM, FRM);
    wr(ADDR_CTRL, 8'h3A);
    ext_pwm_in <= 1'b0;
    meas(0, FRM, FRM);
    $display("gate done");
    @(posedge clk_sys);
    external_reset_n <= 1'b0;
    repeat (10) @(posedge clk_sys);
    external_reset_n <= 1'b1;
    repeat (6) @(posedge clk_sys);
    rd(ADDR_CTRL, CTRL_RESET);
    wait_chk(1, 6'h08);
    $display("pin reset done");
    end_of_test();
  end
endmodule

bind kldc_top kldc_sva #(.FRAME_CYCLES(FRAME_CYCLES), .SOFT_START_CYCLES(SOFT_START_CYCLES))
  u_kldc_sva (.clk_sys(clk_sys), .resetn(resetn), .reg_wr(reg_wr), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .led_sink_one(led_sink_one), .led_sink_two(led_sink_two),
  .led_sink_three(led_sink_three), .output_mode_select(output_mode_select),
  .boost_run(boost_run), .boost_soft_start(boost_soft_start));
